// file: core/cpuam_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module cpuam_decoder (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Program and data memory
  output logic [15:0] mem_addr,
  output logic mem_rd,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  // CPU registers and flags
  input wire logic [7:0] index_reg,
  input wire logic flag_c,
  input wire logic flag_z,
  input wire logic flag_n,
  input wire logic flag_h,
  input wire logic flag_i,
  input wire logic irq_pin,
  // Execute sequencer
  input wire logic exec_done,
  input wire logic pc_load,
  input wire logic [15:0] pc_load_value,
  // Decoded instruction
  output logic dec_valid,
  output cpuam_pkg::cpuam_mode_t dec_mode,
  output cpuam_pkg::cpuam_class_t dec_class,
  output cpuam_pkg::cpuam_op_t dec_op,
  output logic [1:0] dec_len,
  output logic dec_uses_mem,
  output logic dec_writeback,
  output logic dec_reg_x,
  output logic [15:0] dec_ea,
  output logic [7:0] dec_data,
  output logic [7:0] dec_offset,
  output logic [2:0] dec_bit_index,
  output logic dec_bit_sense,
  output logic dec_taken,
  output logic [15:0] dec_next_pc,
  output logic [15:0] pc,
  output logic carry_load,
  output logic carry_value
);
  import cpuam_pkg::*;

  // ------------------------------------------------------------
  // Opcode decoding
  // ------------------------------------------------------------
  function automatic cpuam_mode_t mode_of(input logic [7:0] opc);
    case (opc[7:4])
      4'h0, 4'h1, 4'h3, 4'hb: mode_of = MODE_DIR;
      4'h2: mode_of = MODE_REL;
      4'h6, 4'he: mode_of = MODE_IX1;
      4'h7, 4'hf: mode_of = MODE_IX;
      4'ha: mode_of = (opc == CPUAM_OPC_BRANCH_SUB) ? MODE_REL : MODE_IMM;
      4'hc: mode_of = MODE_EXT;
      4'hd: mode_of = MODE_IX2;
      default: mode_of = MODE_INH;
    endcase
  endfunction

  function automatic cpuam_op_t rmw_op(input logic [3:0] lo);
    case (lo)
      4'h0: rmw_op = OP_NEGATE;
      4'h3: rmw_op = OP_COMPLEMENT;
      4'h4: rmw_op = OP_SHR_LOGIC;
      4'h6: rmw_op = OP_ROT_RIGHT;
      4'h7: rmw_op = OP_SHR_ARITH;
      4'h8: rmw_op = OP_SHL;
      4'h9: rmw_op = OP_ROT_LEFT;
      4'ha: rmw_op = OP_DECREMENT;
      4'hc: rmw_op = OP_INCREMENT;
      4'hd: rmw_op = OP_TEST_NEG_ZERO;
      4'hf: rmw_op = OP_CLEAR;
      default: rmw_op = OP_CONTROL;
    endcase
  endfunction

  function automatic cpuam_op_t regmem_op(input logic [3:0] lo);
    case (lo)
      4'h0: regmem_op = OP_SUBTRACT;
      4'h1: regmem_op = OP_COMPARE_A;
      4'h2: regmem_op = OP_SUB_CARRY;
      4'h3: regmem_op = OP_COMPARE_X;
      4'h4: regmem_op = OP_AND;
      4'h5: regmem_op = OP_BIT_TEST;
      4'h6: regmem_op = OP_LOAD_A;
      4'h7: regmem_op = OP_STORE_A;
      4'h8: regmem_op = OP_XOR;
      4'h9: regmem_op = OP_ADD_CARRY;
      4'ha: regmem_op = OP_OR;
      4'hb: regmem_op = OP_ADD;
      4'hc: regmem_op = OP_UNCOND_JUMP;
      4'hd: regmem_op = OP_JUMP_SUB;
      4'he: regmem_op = OP_LOAD_X;
      default: regmem_op = OP_STORE_X;
    endcase
  endfunction

  // Bit number sits in opcode bits 3:1, sense in bit 0
  function automatic cpuam_op_t op_of(input logic [7:0] opc);
    case (opc[7:4])
      4'h0: op_of = opc[0] ? OP_BRANCH_IF_BIT_ZERO : OP_BRANCH_IF_BIT_ONE;
      4'h1: op_of = opc[0] ? OP_MEM_BIT_ZERO : OP_MEM_BIT_ONE;
      4'h2: op_of = OP_BRANCH;
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
        op_of = (opc == CPUAM_OPC_MULT) ? OP_MULTIPLY : rmw_op(opc[3:0]);
      end
      4'h8, 4'h9: op_of = OP_CONTROL;
      4'ha: op_of = (opc == CPUAM_OPC_BRANCH_SUB) ? OP_BRANCH_SUB : regmem_op(opc[3:0]);
      default: op_of = regmem_op(opc[3:0]);
    endcase
  endfunction

  function automatic cpuam_class_t class_of(input cpuam_op_t op);
    case (op)
      OP_CONTROL: class_of = CLS_CONTROL;
      OP_BRANCH, OP_BRANCH_SUB: class_of = CLS_BRANCH;
      OP_BRANCH_IF_BIT_ONE, OP_BRANCH_IF_BIT_ZERO: class_of = CLS_BIT_BRANCH;
      OP_MEM_BIT_ONE, OP_MEM_BIT_ZERO: class_of = CLS_BIT_SETCLR;
      OP_UNCOND_JUMP, OP_JUMP_SUB: class_of = CLS_JUMP;
      OP_SUBTRACT, OP_COMPARE_A, OP_SUB_CARRY, OP_COMPARE_X, OP_AND, OP_BIT_TEST,
      OP_LOAD_A, OP_STORE_A, OP_XOR, OP_ADD_CARRY, OP_OR, OP_ADD, OP_LOAD_X,
      OP_STORE_X, OP_MULTIPLY: class_of = CLS_REGMEM;
      default: class_of = CLS_RMW;
    endcase
  endfunction

  function automatic logic [1:0] len_of(input logic [7:0] opc);
    if (class_of(op_of(opc)) == CLS_BIT_BRANCH) begin
      len_of = CPUAM_LEN3;
    end else begin
      case (mode_of(opc))
        MODE_INH, MODE_IX: len_of = CPUAM_LEN1;
        MODE_EXT, MODE_IX2: len_of = CPUAM_LEN3;
        default: len_of = CPUAM_LEN2;
      endcase
    end
  endfunction

  // Odd low nibble inverts the even condition
  function automatic logic branch_cond(input logic [3:0] lo, input logic c, input logic z,
                                       input logic n, input logic h, input logic i,
                                       input logic irq);
    logic base;
    case (lo[3:1])
      3'h0: base = 1'b1;
      3'h1: base = ~(c | z);
      3'h2: base = ~c;
      3'h3: base = ~z;
      3'h4: base = ~h;
      3'h5: base = ~n;
      3'h6: base = ~i;
      default: base = ~irq;
    endcase
    branch_cond = base ^ lo[0];
  endfunction

  // ------------------------------------------------------------
  // State and signals
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OPCODE, ST_ARG1, ST_ARG2, ST_TEST, ST_ISSUE, ST_EXEC
  } cpuam_state_t;

  cpuam_state_t state_q, state_d;
  logic [15:0] pc_q, pc_d, addr_q, addr_d;
  logic rd_q, rd_d;
  logic [7:0] opc_q, opc_d, b1_q, b1_d, b2_q, b2_d, test_q, test_d;
  logic valid_q, valid_d, uses_mem_q, uses_mem_d, wb_q, wb_d, regx_q, regx_d;
  logic sense_q, sense_d, taken_q, taken_d, cload_q, cload_d, cval_q, cval_d;
  cpuam_mode_t mode_q, mode_d;
  cpuam_class_t cls_q, cls_d;
  cpuam_op_t op_q, op_d;
  logic [1:0] len_q, len_d;
  logic [15:0] ea_q, ea_d, next_q, next_d;
  logic [7:0] data_q, data_d, off_q, off_d;
  logic [2:0] bidx_q, bidx_d;
  logic irq_level;
  cpuam_mode_t mode_w;
  cpuam_op_t op_w;
  cpuam_class_t cls_w;
  logic [7:0] off_w;
  logic [15:0] ea_w, target_w;
  logic tbit_w, taken_w, got;

  // IRQ pin comes from outside the clock domain
  cpuam_pin_sync u_irq_sync (
    .clock(clock),
    .rst(rst),
    .pin(irq_pin),
    .level(irq_level)
  );

  // ------------------------------------------------------------
  // Address generation and branch decision
  // ------------------------------------------------------------
  always_comb begin
    mode_w = mode_of(opc_q);
    op_w = op_of(opc_q);
    cls_w = class_of(op_w);
    off_w = (cls_w == CLS_BIT_BRANCH) ? b2_q : b1_q;
    tbit_w = test_q[opc_q[3:1]];
    target_w = pc_q + {{8{off_w[7]}}, off_w};
    case (mode_w)
      MODE_DIR: ea_w = {CPUAM_PAGE0, b1_q};
      MODE_EXT: ea_w = {b1_q, b2_q};
      MODE_IX: ea_w = {CPUAM_PAGE0, index_reg};
      MODE_IX1: ea_w = {CPUAM_PAGE0, b1_q} + {CPUAM_PAGE0, index_reg};
      MODE_IX2: ea_w = {b1_q, b2_q} + {CPUAM_PAGE0, index_reg};
      MODE_REL: ea_w = target_w;
      default: ea_w = 16'h0000;
    endcase
    case (cls_w)
      CLS_BRANCH: begin
        taken_w = (op_w == OP_BRANCH_SUB) ? 1'b1 :
                  branch_cond(opc_q[3:0], flag_c, flag_z, flag_n, flag_h, flag_i, irq_level);
      end
      CLS_BIT_BRANCH: taken_w = tbit_w ^ opc_q[0];
      default: taken_w = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Fetch sequencer
  // ------------------------------------------------------------
  // A request holds until acknowledged; the address may move back to back
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    addr_d = addr_q;
    rd_d = rd_q;
    opc_d = opc_q;
    b1_d = b1_q;
    b2_d = b2_q;
    test_d = test_q;
    got = rd_q & mem_ack;
    case (state_q)
      ST_OPCODE: begin
        if (got) begin
          opc_d = mem_rdata;
          pc_d = pc_q + 16'h0001;
          addr_d = pc_q + 16'h0001;
          if (len_of(mem_rdata) == CPUAM_LEN1) begin
            rd_d = 1'b0;
            state_d = ST_ISSUE;
          end else begin
            state_d = ST_ARG1;
          end
        end
      end
      ST_ARG1: begin
        if (got) begin
          b1_d = mem_rdata;
          pc_d = pc_q + 16'h0001;
          addr_d = pc_q + 16'h0001;
          if (len_of(opc_q) == CPUAM_LEN3) begin
            state_d = ST_ARG2;
          end else begin
            rd_d = 1'b0;
            state_d = ST_ISSUE;
          end
        end
      end
      ST_ARG2: begin
        if (got) begin
          b2_d = mem_rdata;
          pc_d = pc_q + 16'h0001;
          if (cls_w == CLS_BIT_BRANCH) begin
            addr_d = {CPUAM_PAGE0, b1_q};
            state_d = ST_TEST;
          end else begin
            rd_d = 1'b0;
            state_d = ST_ISSUE;
          end
        end
      end
      ST_TEST: begin
        if (got) begin
          test_d = mem_rdata;
          rd_d = 1'b0;
          state_d = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        state_d = ST_EXEC;
        if (taken_w) begin
          pc_d = target_w;
        end else if (cls_w == CLS_JUMP) begin
          pc_d = ea_w;
        end
      end
      ST_EXEC: begin
        if (pc_load) begin
          pc_d = pc_load_value;
        end
        if (exec_done) begin
          state_d = ST_OPCODE;
          rd_d = 1'b1;
          addr_d = pc_load ? pc_load_value : pc_q;
        end
      end
      default: state_d = ST_OPCODE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_OPCODE;
      pc_q <= CPUAM_RESET_PC;
      addr_q <= CPUAM_RESET_PC;
      rd_q <= 1'b1;
      opc_q <= 8'h00;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
      test_q <= 8'h00;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
      opc_q <= opc_d;
      b1_q <= b1_d;
      b2_q <= b2_d;
      test_q <= test_d;
    end
  end

  // ------------------------------------------------------------
  // Decoded instruction outputs
  // ------------------------------------------------------------
  always_comb begin
    valid_d = 1'b0;
    cload_d = 1'b0;
    cval_d = cval_q;
    mode_d = mode_q;
    cls_d = cls_q;
    op_d = op_q;
    len_d = len_q;
    uses_mem_d = uses_mem_q;
    wb_d = wb_q;
    regx_d = regx_q;
    ea_d = ea_q;
    data_d = data_q;
    off_d = off_q;
    bidx_d = bidx_q;
    sense_d = sense_q;
    taken_d = taken_q;
    next_d = next_q;
    if (state_q == ST_ISSUE) begin
      valid_d = 1'b1;
      mode_d = mode_w;
      cls_d = cls_w;
      op_d = op_w;
      len_d = len_of(opc_q);
      // Inherent, immediate and relative forms never touch data memory
      uses_mem_d = (cls_w inside {CLS_REGMEM, CLS_RMW, CLS_BIT_SETCLR}) &&
                   !(mode_w inside {MODE_INH, MODE_IMM, MODE_REL});
      wb_d = ((cls_w == CLS_RMW) && (op_w != OP_TEST_NEG_ZERO)) ||
             (cls_w == CLS_BIT_SETCLR) || (op_w inside {OP_STORE_A, OP_STORE_X});
      regx_d = (opc_q[7:4] == 4'h5) || (op_w inside {OP_COMPARE_X, OP_LOAD_X, OP_STORE_X});
      ea_d = ea_w;
      data_d = (cls_w == CLS_BIT_BRANCH) ? test_q : b1_q;
      off_d = off_w;
      bidx_d = opc_q[3:1];
      sense_d = ~opc_q[0];
      taken_d = taken_w;
      next_d = pc_q;
      cload_d = (cls_w == CLS_BIT_BRANCH);
      cval_d = (cls_w == CLS_BIT_BRANCH) ? tbit_w : cval_q;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      valid_q <= 1'b0;
      cload_q <= 1'b0;
      cval_q <= 1'b0;
      mode_q <= MODE_INH;
      cls_q <= CLS_CONTROL;
      op_q <= OP_CONTROL;
      len_q <= CPUAM_LEN1;
      uses_mem_q <= 1'b0;
      wb_q <= 1'b0;
      regx_q <= 1'b0;
      ea_q <= 16'h0000;
      data_q <= 8'h00;
      off_q <= 8'h00;
      bidx_q <= 3'h0;
      sense_q <= 1'b0;
      taken_q <= 1'b0;
      next_q <= CPUAM_RESET_PC;
    end else begin
      valid_q <= valid_d;
      cload_q <= cload_d;
      cval_q <= cval_d;
      mode_q <= mode_d;
      cls_q <= cls_d;
      op_q <= op_d;
      len_q <= len_d;
      uses_mem_q <= uses_mem_d;
      wb_q <= wb_d;
      regx_q <= regx_d;
      ea_q <= ea_d;
      data_q <= data_d;
      off_q <= off_d;
      bidx_q <= bidx_d;
      sense_q <= sense_d;
      taken_q <= taken_d;
      next_q <= next_d;
    end
  end

  assign mem_addr = addr_q;
  assign mem_rd = rd_q;
  assign dec_valid = valid_q;
  assign dec_mode = mode_q;
  assign dec_class = cls_q;
  assign dec_op = op_q;
  assign dec_len = len_q;
  assign dec_uses_mem = uses_mem_q;
  assign dec_writeback = wb_q;
  assign dec_reg_x = regx_q;
  assign dec_ea = ea_q;
  assign dec_data = data_q;
  assign dec_offset = off_q;
  assign dec_bit_index = bidx_q;
  assign dec_bit_sense = sense_q;
  assign dec_taken = taken_q;
  assign dec_next_pc = next_q;
  assign pc = pc_q;
  assign carry_load = cload_q;
  assign carry_value = cval_q;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_inh_no_addr: assert property (@(posedge clock) disable iff (rst)
    dec_valid && dec_mode == MODE_INH |-> dec_len == CPUAM_LEN1 && !dec_uses_mem)
    else $error("inherent form has wrong length or uses memory");
  a_imm_two_bytes: assert property (@(posedge clock) disable iff (rst)
    dec_valid && dec_mode == MODE_IMM |-> dec_len == CPUAM_LEN2 && !dec_uses_mem)
    else $error("immediate form has wrong length or uses memory");
  a_dir_page_zero: assert property (@(posedge clock) disable iff (rst)
    dec_valid && dec_mode == MODE_DIR |-> dec_ea[15:8] == CPUAM_PAGE0)
    else $error("direct address left page zero");
  a_ix_page_zero: assert property (@(posedge clock) disable iff (rst)
    dec_valid && dec_mode == MODE_IX |-> dec_ea == {CPUAM_PAGE0, $past(index_reg)})
    else $error("indexed address not the index byte");
  a_ix1_offset_sum: assert property (@(posedge clock) disable iff (rst)
    dec_valid && dec_mode == MODE_IX1 |->
      dec_ea == {CPUAM_PAGE0, $past(b1_q)} + {CPUAM_PAGE0, $past(index_reg)} &&
      dec_ea <= CPUAM_IX1_TOP)
    else $error("8-bit offset address wrong");
  a_ix2_offset_sum: assert property (@(posedge clock) disable iff (rst)
    dec_valid && dec_mode == MODE_IX2 |->
      dec_ea == {$past(b1_q), $past(b2_q)} + {CPUAM_PAGE0, $past(index_reg)} &&
      dec_len == CPUAM_LEN3)
    else $error("16-bit offset address wrong");
  a_taken_target: assert property (@(posedge clock) disable iff (rst)
    dec_valid && dec_taken |-> pc == dec_next_pc + {{8{dec_offset[7]}}, dec_offset})
    else $error("taken branch target wrong");
  a_not_taken_next: assert property (@(posedge clock) disable iff (rst)
    dec_valid && !dec_taken && dec_class == CLS_BRANCH |-> pc == dec_next_pc)
    else $error("untaken branch moved the program counter");
  a_branch_relative: assert property (@(posedge clock) disable iff (rst)
    dec_valid && dec_class == CLS_BRANCH |-> dec_mode == MODE_REL)
    else $error("branch not in relative form");
  a_test_no_write: assert property (@(posedge clock) disable iff (rst)
    dec_valid && dec_op == OP_TEST_NEG_ZERO |-> !dec_writeback)
    else $error("negative-zero test writes back");
  a_bit_carry_copy: assert property (@(posedge clock) disable iff (rst)
    dec_valid && dec_class == CLS_BIT_BRANCH |->
      carry_load && carry_value == dec_data[dec_bit_index] && dec_len == CPUAM_LEN3)
    else $error("tested bit not copied to carry");
  a_fetch_resume: assert property (@(posedge clock) disable iff (rst)
    state_q == ST_EXEC && exec_done |=> mem_rd && state_q == ST_OPCODE)
    else $error("fetch did not resume after execute");
endmodule // cpuam_decoder
`default_nettype wire

// file: shared/cpuam_pkg.sv
// Function
// - Inherent: one byte, no address, registers only
// - Immediate: two bytes, literal, no address
// - Direct: two bytes, high address zero
// - Extended: three bytes, high then low
// - Indexed no offset: one byte, page zero
// - Indexed 8-bit: index plus byte, unsigned
// - Indexed 16-bit: offset high first plus index
// - Taken branch adds signed offset to next
// - Branches relative; jumps have no register operand
// - Read-modify-write writes back, except negative-zero test
// - Shifts, rotates, clear, complement, negate, inc, dec, bits
// - Register/memory ops: one register, one memory
// - Bit branch: three bytes, address then offset
// - Bit number and sense come from opcode
// - Tested bit always copied into carry
// - Full conditional branch set, always, never, subroutine
package cpuam_pkg;

  localparam logic [15:0] CPUAM_RESET_PC = 16'h0000;
  localparam logic [7:0] CPUAM_PAGE0 = 8'h00;
  localparam logic [15:0] CPUAM_IX1_TOP = 16'h01fe;
  localparam logic [7:0] CPUAM_OPC_BRANCH_SUB = 8'had;
  localparam logic [7:0] CPUAM_OPC_MULT = 8'h42;
  localparam logic [1:0] CPUAM_LEN1 = 2'h1;
  localparam logic [1:0] CPUAM_LEN2 = 2'h2;
  localparam logic [1:0] CPUAM_LEN3 = 2'h3;
  localparam int CPUAM_SYNC_STAGES = 3;
  localparam logic CPUAM_PIN_RESET = 1'b1;

  typedef enum logic [2:0] {
    MODE_INH, MODE_IMM, MODE_DIR, MODE_EXT, MODE_IX, MODE_IX1, MODE_IX2, MODE_REL
  } cpuam_mode_t;

  typedef enum logic [2:0] {
    CLS_CONTROL, CLS_REGMEM, CLS_RMW, CLS_BRANCH, CLS_BIT_BRANCH, CLS_BIT_SETCLR, CLS_JUMP
  } cpuam_class_t;

  typedef enum logic [5:0] {
    OP_CONTROL, OP_NEGATE, OP_COMPLEMENT, OP_SHR_LOGIC, OP_ROT_RIGHT, OP_SHR_ARITH,
    OP_SHL, OP_ROT_LEFT, OP_DECREMENT, OP_INCREMENT, OP_TEST_NEG_ZERO, OP_CLEAR,
    OP_MEM_BIT_ONE, OP_MEM_BIT_ZERO, OP_SUBTRACT, OP_COMPARE_A, OP_SUB_CARRY,
    OP_COMPARE_X, OP_AND, OP_BIT_TEST, OP_LOAD_A, OP_STORE_A, OP_XOR, OP_ADD_CARRY,
    OP_OR, OP_ADD, OP_UNCOND_JUMP, OP_JUMP_SUB, OP_LOAD_X, OP_STORE_X, OP_MULTIPLY,
    OP_BRANCH, OP_BRANCH_SUB, OP_BRANCH_IF_BIT_ONE, OP_BRANCH_IF_BIT_ZERO
  } cpuam_op_t;

endpackage

// file: core/cpuam_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cpuam_pin_sync #(
  parameter int STAGES = cpuam_pkg::CPUAM_SYNC_STAGES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Raw pin and filtered level
  input wire logic pin,
  output logic level
);
  import cpuam_pkg::*;

  logic [STAGES-1:0] sync_q;
  logic [STAGES-1:0] sync_d;
  logic level_q;
  logic level_d;

  if (STAGES < 3) begin : g_bad_stages
    $error("cpuam_pin_sync needs at least three stages");
  end

  // Level only moves once the last two stages agree
  always_comb begin
    sync_d = {sync_q[STAGES-2:0], pin};
    level_d = (sync_q[STAGES-1] == sync_q[STAGES-2]) ? sync_q[STAGES-1] : level_q;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_q <= {STAGES{CPUAM_PIN_RESET}};
      level_q <= CPUAM_PIN_RESET;
    end else begin
      sync_q <= sync_d;
      level_q <= level_d;
    end
  end

  assign level = level_q;
endmodule // cpuam_pin_sync
`default_nettype wire

// file: verif/cpuam_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpuam_mem_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Byte bus
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  output logic mem_ack,
  output logic [7:0] mem_rdata
);
  logic [7:0] bytes [0:65535];
  logic [7:0] last_q;
  logic [1:0] wait_q;
  integer seed = 7;
  // Idle data is the inverse of the last byte, so a stale sample cannot match
  assign mem_ack = mem_rd && (wait_q == 2'h0);
  assign mem_rdata = mem_ack ? bytes[mem_addr] : ~last_q;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_q <= 2'h0;
      last_q <= 8'h00;
    end else if (mem_ack) begin
      last_q <= mem_rdata;
      wait_q <= 2'($unsigned($random(seed)) % 3);
    end else if (wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end
  end
endmodule // cpuam_mem_model
`default_nettype wire

// file: verif/cpuam_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cpuam_decoder_tb;
  import cpuam_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [15:0] mem_addr;
  logic mem_rd, mem_ack;
  logic [7:0] mem_rdata;
  logic [7:0] index_reg = 8'hff;
  logic irq_pin = 1'b1;
  logic flag_c = 1'b0, flag_z = 1'b0, flag_n = 1'b0, flag_h = 1'b0, flag_i = 1'b0;
  logic exec_done = 1'b0, pc_load = 1'b0;
  logic [15:0] pc_load_value = 16'h0000;
  logic dec_valid, dec_uses_mem, dec_writeback, dec_reg_x, dec_bit_sense, dec_taken;
  logic carry_load, carry_value;
  cpuam_mode_t dec_mode;
  cpuam_class_t dec_class;
  cpuam_op_t dec_op;
  logic [1:0] dec_len;
  logic [2:0] dec_bit_index;
  logic [15:0] dec_ea, dec_next_pc, pc;
  logic [7:0] dec_data, dec_offset, op, b2, b3, tb_byte;
  logic [15:0] base = 16'h0000;
  integer seed = 41969;
  integer fail_count = 0;
  integer total_checks = 0;

  cpuam_decoder dut (
    .clock(clock), .rst(rst), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .index_reg(index_reg), .flag_c(flag_c), .flag_z(flag_z),
    .flag_n(flag_n), .flag_h(flag_h), .flag_i(flag_i), .irq_pin(irq_pin),
    .exec_done(exec_done), .pc_load(pc_load), .pc_load_value(pc_load_value),
    .dec_valid(dec_valid), .dec_mode(dec_mode), .dec_class(dec_class), .dec_op(dec_op),
    .dec_len(dec_len), .dec_uses_mem(dec_uses_mem), .dec_writeback(dec_writeback),
    .dec_reg_x(dec_reg_x), .dec_ea(dec_ea), .dec_data(dec_data), .dec_offset(dec_offset),
    .dec_bit_index(dec_bit_index), .dec_bit_sense(dec_bit_sense), .dec_taken(dec_taken),
    .dec_next_pc(dec_next_pc), .pc(pc), .carry_load(carry_load), .carry_value(carry_value)
  );
  cpuam_mem_model mem (
    .clock(clock), .rst(rst), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );

  // ----------------------------------------
  // Expectations and checks
  // ----------------------------------------
  function automatic logic br_cond(input logic [3:0] c);
    logic r;
    case (c[3:1])
      3'h0: r = 1'b1;
      3'h1: r = ~(flag_c | flag_z);
      3'h2: r = ~flag_c;
      3'h3: r = ~flag_z;
      3'h4: r = ~flag_h;
      3'h5: r = ~flag_n;
      3'h6: r = ~flag_i;
      default: r = ~irq_pin;
    endcase
    return r ^ c[0];
  endfunction

  function automatic logic [15:0] rel(input logic [15:0] nxt, input logic [7:0] off);
    return nxt + {{8{off[7]}}, off};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic pick(input integer i);
    logic [31:0] r;
    r = $random(seed);
    case (r[2:0] % 5)
      0: op = {4'ha + r[10:8] % 3'h6, r[12] ? 4'he : 4'h6};
      1: op = {4'h2, r[11:8]};
      2: op = {4'h0, r[11:8]};
      3: op = {7'h1e, r[8]};
      default: op = 8'h4c;
    endcase
    b2 = r[23:16];
    b3 = r[31:24];
    tb_byte = 8'($random(seed));
    if (i == 0) begin
      op = 8'he6;
      b2 = 8'hff;
    end
    if (i == 1 || i == 2) begin
      op = 8'h20;
      b2 = (i == 1) ? 8'h80 : 8'h7f;
    end
    mem.bytes[base] = op;
    mem.bytes[base + 16'h1] = b2;
    mem.bytes[base + 16'h2] = b3;
    if (op[7:4] == 4'h0) begin
      b2 = b2 | 8'h10;
      mem.bytes[base + 16'h1] = b2;
      mem.bytes[{8'h00, b2}] = tb_byte;
    end
  endtask

  task automatic check_cur();
    logic [15:0] nxt, ea, tgt;
    logic [1:0] len;
    logic tk;
    logic bb;
    integer n;
    cpuam_class_t cls;
    bb = (op[7:4] == 4'h0);
    cls = bb ? CLS_BIT_BRANCH : (op[7:4] == 4'h2) ? CLS_BRANCH :
      (op[7:4] inside {4'h3, 4'h4}) ? CLS_RMW : CLS_REGMEM;
    len = (op[7:4] inside {4'h0, 4'hc, 4'hd}) ? 2'h3 : (op[7:4] inside {4'h4, 4'hf}) ? 2'h1 : 2'h2;
    nxt = base + 16'(len);
    tgt = bb ? rel(nxt, b3) : rel(nxt, b2);
    tk = bb ? tb_byte[op[3:1]] ^ op[0] : (op[7:4] == 4'h2) && br_cond(op[3:0]);
    case (op[7:4])
      4'hc: ea = {b2, b3};
      4'hd: ea = {b2, b3} + 16'(index_reg);
      4'he: ea = 16'(b2) + 16'(index_reg);
      4'hf: ea = {8'h00, index_reg};
      4'h2: ea = tgt;
      default: ea = {8'h00, b2};
    endcase
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (dec_valid !== 1'b1 && n < 40);
    check(16'(n < 40), 16'h1);
    check(16'(dec_len), 16'(len));
    check(dec_next_pc, nxt);
    check(pc, tk ? tgt : nxt);
    check(16'({dec_taken, carry_load}), 16'({tk, bb}));
    if (!(op[7:4] inside {4'h0, 4'h4, 4'ha})) check(dec_ea, ea);
    if (bb) check(16'({carry_value, dec_bit_index, dec_bit_sense, dec_offset}),
      16'({tb_byte[op[3:1]], op[3:1], ~op[0], b3}));
    if (op[7:4] inside {4'h3, 4'h4})
      check(16'(dec_writeback), 16'(op[0] == 1'b0));
    if (op[7:4] inside {4'h3, 4'h4})
      check(16'(dec_op), 16'(op[0] ? OP_TEST_NEG_ZERO : OP_INCREMENT));
    check(16'(dec_uses_mem), 16'(op[7:4] inside {4'h3, [4'hb:4'hf]}));
    check(16'(dec_class), 16'(cls));
    check(16'(dec_reg_x), 16'(op[7:4] >= 4'ha && op[3:0] == 4'he));
    if (op[7:4] == 4'ha) check(16'(dec_data), 16'(b2));
    if (op[7:4] == 4'h2) check(16'(dec_mode), 16'(MODE_REL));
  endtask

  // ----------------------------------------
  // Clock, stimulus and watchdog
  // ----------------------------------------
  initial begin
    forever #2 clock = ~clock;
  end

  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end

  initial begin
    pick(0);
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    for (int i = 1; i <= 150; i++) begin
      check_cur();
      base = (i % 50 == 0) ? 16'h0000 : 16'h1000 + 16'($random(seed) & 32'h7fff);
      pick(i);
      @(posedge clock);
      if (base == 16'h0000) begin
        // Reset in mid-execute must restart the fetch from address zero
        rst <= 1'b1;
        irq_pin <= 1'b1;
        @(posedge clock);
        #1;
        check(mem_addr | pc, 16'h0000);
        @(posedge clock);
        rst <= 1'b0;
      end else begin
        // Pin moves one idle cycle early, so its sync settles before the issue edge
        irq_pin <= 1'($random(seed));
        @(posedge clock);
        exec_done <= 1'b1;
        pc_load <= 1'b1;
        pc_load_value <= base;
        index_reg <= 8'($random(seed));
        {flag_c, flag_z, flag_n, flag_h, flag_i} <= 5'($random(seed));
        @(posedge clock);
        exec_done <= 1'b0;
        pc_load <= 1'b0;
      end
    end
    print_verdict();
  end
endmodule // cpuam_decoder_tb
`default_nettype wire
